// File: slcr_link_regs.sv
// link control registers on classic wishbone and the transmit sequencer they steer
// assumes wishbone master and sample source on REF_CLK_IN; resync pins asynchronous
//
// What this block does
// - lane mapping bit clear: link uses lanes zero to L-1
// - lane mapping bit set: lanes four to 4+L-1, lower four idle
// - resync source zero takes the request from the single-ended pin
// - source two ignores all pins, only the software request counts
// - sample format bit: zero offset binary, one two's complement
// - in 8b/10b modes scramble when the scrambler bit is one
// - in 64b/66b modes always scramble, ignoring the scrambler bit
// - code ten holds outputs low, code eleven holds them high
// - code fifteen sends 0x00ff words, code sixteen sends k28.7
// - code zero is normal data; 12 and 17-31 are reserved
// - link identifier goes out in the second alignment multiframe
// - link disabled: block reset, serializers down, clocks gated, counter reset
// - software resync bit at zero requests resynchronisation
`timescale 1ns/1ns
`default_nettype none
`include "slcr_defines.svh"
module slcr_link_regs (
	// clock and reset
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_IN,
	// wishbone slave
	input  wire logic        WB_CYC_IN,
	input  wire logic        WB_STB_IN,
	input  wire logic        WB_WE_IN,
	input  wire logic [11:0] WB_ADR_IN,
	input  wire logic [3:0]  WB_SEL_IN,
	input  wire logic [31:0] WB_DAT_IN,
	output logic      [31:0] WB_DAT_OUT,
	output logic             WB_ACK_OUT,
	// samples and resync pins
	input  wire logic [11:0] SAMPLE_IN,
	input  wire logic        SINGLE_ENDED_RESYNC_PIN_N_IN,
	input  wire logic        TIMESTAMP_PAIR_INPUT_N_IN,
	// lane side
	output logic      [15:0] LANE_DATA_OUT,
	output logic      [1:0]  LANE_K_OUT,
	output logic             LANE_RAW_OUT,
	output logic      [7:0]  LANE_ACTIVE_OUT,
	output logic             RESYNC_REQ_N_OUT,
	// power and reset of the link logic
	output logic             SERDES_PD_OUT,
	output logic             LINK_RST_OUT,
	output logic             LINK_CLK_EN_OUT,
	output logic             MF_CNT_RST_OUT
);
	slcr_pkg::slcr_main_t r;
	slcr_pkg::slcr_main_t n;
	logic [9:0]  idx;
	logic        req;
	logic        wr;
	logic [7:0]  rd;
	logic [11:0] smp;
	logic [30:0] scr_res;
	logic [17:0] ila;
	logic        pat_on;
	logic [15:0] pg_word;
	logic [1:0]  pg_k;
	logic        pg_raw;
	logic        resync_n;

	// lanes in use; more than four with upper mapping is cut to lanes four to seven, which is undefined anyway
	function automatic logic [7:0] lane_mask(input logic [5:0] mode, input logic upper);
		logic [7:0] m;
		case (mode[1:0])
			2'h0: m = 8'h01;
			2'h1: m = 8'h03;
			2'h2: m = 8'h0f;
			default: m = 8'hff;
		endcase
		return upper ? {m[3:0], 4'h0} : m;
	endfunction

	// self-synchronous 1 + x^14 + x^15, msb first
	function automatic logic [30:0] scramble16(input logic [14:0] s, input logic [15:0] d);
		logic [14:0] q;
		logic [15:0] o;
		q = s;
		o = 16'h0000;
		for (int i = 15; i >= 0; i--) begin
			o[i] = d[i] ^ q[13] ^ q[14];
			q = {q[13:0], o[i]};
		end
		return {q, o};
	endfunction

	// alignment word {k flags, data} for a position in the sequence
	function automatic logic [17:0] ila_word(input logic [1:0] mf, input logic [3:0] w,
		input logic [7:0] lid);
		logic [17:0] v;
		v = {2'b00, 16'h0000};
		if (w == 4'h0) begin
			v = {2'b10, `SLCR_K28_0, 8'h00};
		end else if (w == `SLCR_MF_LAST) begin
			v = {2'b01, 8'h00, `SLCR_K28_3};
		end else if (mf == 2'h1 && w == 4'h1) begin
			v = {2'b10, `SLCR_K28_4, 8'h00};
		end else if (mf == 2'h1 && w == 4'h2) begin
			v = {2'b00, lid, 8'h00};
		end
		return v;
	endfunction

	slcr_resync_sel u_resync (
		.clk_in      (REF_CLK_IN),
		.rst_in      (RST_IN),
		.sel_in      (r.lane[`SLCR_LANE_SEL_HI:`SLCR_LANE_SEL_LO]),
		.sw_n_in     (r.sw_n),
		.ts_on_in    (r.ts_on),
		.se_pin_n_in (SINGLE_ENDED_RESYNC_PIN_N_IN),
		.ts_pin_n_in (TIMESTAMP_PAIR_INPUT_N_IN),
		.req_n_out   (resync_n)
	);

	slcr_pattern_gen u_pattern (
		.clk_in   (REF_CLK_IN),
		.rst_in   (RST_IN),
		.code_in  (r.pat),
		.word_out (pg_word),
		.k_out    (pg_k),
		.raw_out  (pg_raw)
	);

	always_comb begin
		n = r;
		idx = WB_ADR_IN[11:2];
		req = WB_CYC_IN && WB_STB_IN && !r.ack;
		wr = req && WB_WE_IN && WB_SEL_IN[0];
		// reserved bits are not stored and read back as zero
		case (idx)
			`SLCR_IDX_LINK_EN: rd = {7'h00, r.link_en};
			`SLCR_IDX_MODE: rd = {2'h0, r.mode};
			`SLCR_IDX_SYNC: rd = {7'h00, r.sw_n};
			`SLCR_IDX_LANE: rd = {3'h0, r.lane};
			`SLCR_IDX_PAT: rd = {3'h0, r.pat};
			`SLCR_IDX_LID: rd = r.lid;
			`SLCR_IDX_TSRX: rd = {7'h00, r.ts_on};
			default: rd = 8'h00;
		endcase
		n.ack = req;
		if (req && !WB_WE_IN) begin
			n.dat = {24'h000000, rd};
		end
		if (wr) begin
			case (idx)
				`SLCR_IDX_LINK_EN: n.link_en = WB_DAT_IN[0];
				`SLCR_IDX_MODE: n.mode = WB_DAT_IN[5:0];
				`SLCR_IDX_SYNC: n.sw_n = WB_DAT_IN[0];
				`SLCR_IDX_LANE: n.lane = WB_DAT_IN[4:0];
				`SLCR_IDX_PAT: n.pat = WB_DAT_IN[4:0];
				`SLCR_IDX_LID: n.lid = WB_DAT_IN[7:0];
				`SLCR_IDX_TSRX: n.ts_on = WB_DAT_IN[0];
				default: n.ack = req;
			endcase
		end

		// sample coding and scrambling
		smp = SAMPLE_IN;
		if (!r.lane[`SLCR_LANE_FMT_BIT]) begin
			smp = {~SAMPLE_IN[11], SAMPLE_IN[10:0]};
		end
		n.scr_on = r.lane[`SLCR_LANE_SCR_BIT] | r.mode[`SLCR_MODE_64B_BIT];
		scr_res = scramble16(r.payload_whitening_enable, {smp, 4'h0});
		ila = ila_word(r.mfcnt, r.wcnt, r.lid);
		pat_on = r.pat != `SLCR_PAT_NORMAL && r.pat != `SLCR_PAT_ILA;

		n.lanes = lane_mask(r.mode, r.lane[`SLCR_LANE_UPPER_BIT]);
		n.ser_pd = 1'b0;
		n.blk_rst = 1'b0;
		n.clk_en = 1'b1;
		n.mf_rst = 1'b0;
		n.kf = 2'b00;
		n.raw = 1'b0;
		n.data = 16'h0000;

		if (!r.link_en) begin
			// everything downstream sits in reset while the link is off
			n.st = slcr_pkg::SLCR_OFF;
			n.ser_pd = 1'b1;
			n.blk_rst = 1'b1;
			n.clk_en = 1'b0;
			n.mf_rst = 1'b1;
			n.lanes = 8'h00;
			n.wcnt = 4'h0;
			n.mfcnt = 2'h0;
			n.payload_whitening_enable = `SLCR_RST_SCR;
		end else begin
			case (r.st)
				slcr_pkg::SLCR_OFF: begin
					n.st = slcr_pkg::SLCR_SYNC;
				end
				slcr_pkg::SLCR_SYNC: begin
					n.data = {2{`SLCR_K28_5}};
					n.kf = 2'b11;
					n.wcnt = 4'h0;
					n.mfcnt = 2'h0;
					if (resync_n) begin
						// no alignment sequence on 64b/66b links
						n.st = r.mode[`SLCR_MODE_64B_BIT] ? slcr_pkg::SLCR_DATA : slcr_pkg::SLCR_ILA;
					end
				end
				slcr_pkg::SLCR_ILA: begin
					n.data = ila[15:0];
					n.kf = ila[17:16];
					n.wcnt = r.wcnt + 4'h1;
					if (r.wcnt == `SLCR_MF_LAST) begin
						n.mfcnt = r.mfcnt + 2'h1;
						if (r.mfcnt == `SLCR_ILA_LAST_MF) begin
							n.st = (r.pat == `SLCR_PAT_ILA) ? slcr_pkg::SLCR_ILA :
								slcr_pkg::SLCR_DATA;
						end
					end
				end
				slcr_pkg::SLCR_DATA: begin
					if (n.scr_on) begin
						n.data = scr_res[15:0];
						n.payload_whitening_enable = scr_res[30:16];
					end else begin
						n.data = {smp, 4'h0};
					end
					if (!resync_n) begin
						n.st = slcr_pkg::SLCR_SYNC;
					end
				end
				default: n.st = slcr_pkg::SLCR_OFF;
			endcase
			// repeated alignment sequence takes over from any other state
			if (r.pat == `SLCR_PAT_ILA && r.st != slcr_pkg::SLCR_ILA) begin
				n.st = slcr_pkg::SLCR_ILA;
				n.wcnt = 4'h0;
				n.mfcnt = 2'h0;
			end
			if (pat_on) begin
				n.data = pg_word;
				n.kf = pg_k;
				n.raw = pg_raw;
			end
		end

		if (RST_IN) begin
			n = '0;
			n.link_en = `SLCR_RST_LINK_EN;
			n.mode = `SLCR_RST_MODE;
			n.sw_n = `SLCR_RST_SYNC;
			n.lane = `SLCR_RST_LANE;
			n.pat = `SLCR_RST_PAT;
			n.lid = `SLCR_RST_LID;
			n.ts_on = `SLCR_RST_TSRX;
			n.payload_whitening_enable = `SLCR_RST_SCR;
			n.ser_pd = 1'b1;
			n.blk_rst = 1'b1;
			n.mf_rst = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		r <= n;
	end

	assign WB_ACK_OUT = r.ack;
	assign WB_DAT_OUT = r.dat;
	assign LANE_DATA_OUT = r.data;
	assign LANE_K_OUT = r.kf;
	assign LANE_RAW_OUT = r.raw;
	assign LANE_ACTIVE_OUT = r.lanes;
	assign RESYNC_REQ_N_OUT = resync_n;
	assign SERDES_PD_OUT = r.ser_pd;
	assign LINK_RST_OUT = r.blk_rst;
	assign LINK_CLK_EN_OUT = r.clk_en;
	assign MF_CNT_RST_OUT = r.mf_rst;

	sequence s_lid_slot;
		r.link_en && r.st == slcr_pkg::SLCR_ILA && r.mfcnt == 2'h1 && r.wcnt == 4'h2;
	endsequence

	sequence s_plain_data;
		r.link_en && r.st == slcr_pkg::SLCR_DATA && r.pat == `SLCR_PAT_NORMAL &&
			!r.lane[`SLCR_LANE_SCR_BIT] && !r.mode[`SLCR_MODE_64B_BIT];
	endsequence

	a_disabled_hold: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		!r.link_en |=> LINK_RST_OUT && SERDES_PD_OUT && !LINK_CLK_EN_OUT && MF_CNT_RST_OUT
			&& LANE_ACTIVE_OUT == 8'h00)
		else $error("link not held off while disabled");
	a_lower_lanes: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		(r.link_en && r.mode[1:0] == 2'h2 && !r.lane[`SLCR_LANE_UPPER_BIT])
			|=> LANE_ACTIVE_OUT == 8'h0f)
		else $error("lower lane map wrong");
	a_upper_lanes: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		(r.link_en && r.mode[1:0] == 2'h1 && r.lane[`SLCR_LANE_UPPER_BIT])
			|=> LANE_ACTIVE_OUT == 8'h30)
		else $error("upper lane map wrong");
	a_sample_fmt: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		s_plain_data |=> LANE_DATA_OUT[15] ==
			($past(r.lane[`SLCR_LANE_FMT_BIT]) ? $past(SAMPLE_IN[11]) : !$past(SAMPLE_IN[11])))
		else $error("sample format wrong");
	a_scr_off: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		s_plain_data |=> LANE_DATA_OUT[14:4] == $past(SAMPLE_IN[10:0]) && LANE_K_OUT == 2'b00)
		else $error("data scrambled while scrambler off");
	a_scr_forced: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		r.mode[`SLCR_MODE_64B_BIT] |=> r.scr_on)
		else $error("64b66b mode not scrambled");
	a_hold_low: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		(r.link_en && r.pat == `SLCR_PAT_LOW) [*3] |-> LANE_DATA_OUT == 16'h0000 && LANE_RAW_OUT)
		else $error("outputs not held low");
	a_clock_word: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		(r.link_en && r.pat == `SLCR_PAT_CLOCK) [*3] |-> LANE_DATA_OUT == 16'h00ff)
		else $error("clock pattern wrong");
	a_k287_word: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		(r.link_en && r.pat == `SLCR_PAT_K287) [*3] |-> LANE_DATA_OUT == 16'hfcfc &&
			LANE_K_OUT == 2'b11)
		else $error("k28.7 pattern wrong");
	a_lid_slot: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		s_lid_slot ##0 (r.pat == `SLCR_PAT_NORMAL || r.pat == `SLCR_PAT_ILA)
			|=> LANE_DATA_OUT[15:8] == $past(r.lid) && LANE_K_OUT == 2'b00)
		else $error("link identifier missing from second multiframe");
endmodule
`default_nettype wire

// File: slcr_defines.svh
// offsets, field positions, reset values and codes of the link control registers
// assumes inclusion by bare name from every file that decodes them
`ifndef SLCR_DEFINES_SVH
`define SLCR_DEFINES_SVH
// register indexes; byte address is four times the index
`define SLCR_IDX_LINK_EN    10'h200
`define SLCR_IDX_MODE       10'h201
`define SLCR_IDX_SYNC       10'h203
`define SLCR_IDX_LANE       10'h204
`define SLCR_IDX_PAT        10'h205
`define SLCR_IDX_LID        10'h206
`define SLCR_IDX_TSRX       10'h210
// reset values
`define SLCR_RST_LINK_EN    1'h1
`define SLCR_RST_MODE       6'h00
`define SLCR_RST_SYNC       1'h1
`define SLCR_RST_LANE       5'h03
`define SLCR_RST_PAT        5'h00
`define SLCR_RST_LID        8'h00
`define SLCR_RST_TSRX       1'h0
`define SLCR_RST_SCR        15'h7fff
`define SLCR_RST_LFSR       31'h7fffffff
// field positions
`define SLCR_LANE_UPPER_BIT 4
`define SLCR_LANE_SEL_HI    3
`define SLCR_LANE_SEL_LO    2
`define SLCR_LANE_FMT_BIT   1
`define SLCR_LANE_SCR_BIT   0
`define SLCR_MODE_64B_BIT   5
// resync source codes
`define SLCR_SEL_PIN        2'h0
`define SLCR_SEL_TS         2'h1
`define SLCR_SEL_SOFT       2'h2
// pattern select codes
`define SLCR_PAT_NORMAL     5'h00
`define SLCR_PAT_PRBS7      5'h01
`define SLCR_PAT_PRBS15     5'h02
`define SLCR_PAT_PRBS23     5'h03
`define SLCR_PAT_RAMP       5'h04
`define SLCR_PAT_TRANSPORT  5'h05
`define SLCR_PAT_D215       5'h06
`define SLCR_PAT_K285       5'h07
`define SLCR_PAT_ILA        5'h08
`define SLCR_PAT_RPAT       5'h09
`define SLCR_PAT_LOW        5'h0a
`define SLCR_PAT_HIGH       5'h0b
`define SLCR_PAT_PRBS9      5'h0d
`define SLCR_PAT_PRBS31     5'h0e
`define SLCR_PAT_CLOCK      5'h0f
`define SLCR_PAT_K287       5'h10
// characters and alignment framing
`define SLCR_K28_0          8'h1c
`define SLCR_K28_3          8'h7c
`define SLCR_K28_4          8'h9c
`define SLCR_K28_5          8'hbc
`define SLCR_K28_7          8'hfc
`define SLCR_D21_5          8'hb5
`define SLCR_CLK_WORD       16'h00ff
`define SLCR_MF_LAST        4'hf
`define SLCR_ILA_LAST_MF    2'h3
`endif

// File: slcr_pkg.sv
// types shared by the link control register block
// assumes nothing of its surroundings
`default_nettype none
package slcr_pkg;
	typedef enum logic [1:0] {SLCR_OFF, SLCR_SYNC, SLCR_ILA, SLCR_DATA} slcr_link_st_t;
	typedef struct packed {
		logic          ack;
		logic [31:0]   dat;
		logic          link_en;
		logic          ts_on;
		logic [5:0]    mode;
		logic          sw_n;
		logic [4:0]    lane;
		logic [4:0]    pat;
		logic [7:0]    lid;
		slcr_link_st_t st;
		logic [3:0]    wcnt;
		logic [1:0]    mfcnt;
		logic [14:0]   payload_whitening_enable;
		logic [15:0]   data;
		logic [1:0]    kf;
		logic          raw;
		logic [7:0]    lanes;
		logic          ser_pd;
		logic          blk_rst;
		logic          clk_en;
		logic          mf_rst;
		logic          scr_on;
	} slcr_main_t;
	typedef struct packed {
		logic [30:0] lfsr;
		logic [15:0] cnt;
		logic [15:0] word;
		logic [1:0]  k;
		logic        raw;
	} slcr_pat_t;
	typedef struct packed {
		logic se_s1;
		logic se_s2;
		logic ts_s1;
		logic ts_s2;
		logic req_n;
	} slcr_sync_t;
endpackage
`default_nettype wire

// File: slcr_resync_sel.sv
// resync request source selection with pin synchronisers
// assumes pins are asynchronous to clk_in; register inputs share clk_in
`timescale 1ns/1ns
`default_nettype none
`include "slcr_defines.svh"
module slcr_resync_sel (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// settings
	input  wire logic [1:0] sel_in,
	input  wire logic       sw_n_in,
	input  wire logic       ts_on_in,
	// pins
	input  wire logic       se_pin_n_in,
	input  wire logic       ts_pin_n_in,
	// result
	output logic            req_n_out
);
	slcr_pkg::slcr_sync_t r;
	slcr_pkg::slcr_sync_t n;

	always_comb begin
		n = r;
		n.se_s1 = se_pin_n_in;
		n.se_s2 = r.se_s1;
		n.ts_s1 = ts_pin_n_in;
		n.ts_s2 = r.ts_s1;
		// the software bit can always request, whatever the source
		case (sel_in)
			`SLCR_SEL_PIN: n.req_n = r.se_s2 & sw_n_in;
			`SLCR_SEL_TS: n.req_n = (r.ts_s2 | ~ts_on_in) & sw_n_in;
			default: n.req_n = sw_n_in;
		endcase
		if (rst_in) begin
			n = '1;
		end
	end

	always_ff @(posedge clk_in) begin
		r <= n;
	end

	assign req_n_out = r.req_n;

	a_pin_path: assert property (@(posedge clk_in) disable iff (rst_in)
		(sel_in == `SLCR_SEL_PIN) [*4] |-> req_n_out == ($past(se_pin_n_in, 3) & $past(sw_n_in)))
		else $error("resync pin path wrong");
	a_sw_only: assert property (@(posedge clk_in) disable iff (rst_in)
		$past(sel_in) == `SLCR_SEL_SOFT |-> req_n_out == $past(sw_n_in))
		else $error("soft resync not sole source");
endmodule
`default_nettype wire

// File: slcr_pattern_gen.sv
// test pattern source: prbs, ramp, fixed characters and held levels
// assumes the code input is a register on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "slcr_defines.svh"
module slcr_pattern_gen (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// selection
	input  wire logic [4:0]  code_in,
	// pattern word
	output logic      [15:0] word_out,
	output logic      [1:0]  k_out,
	output logic             raw_out
);
	// four arbitrary jitter-rich words, cycled one per clock
	localparam logic [63:0] RPAT_TBL = 64'hbed7_2347_6bb3_148f;

	slcr_pkg::slcr_pat_t r;
	slcr_pkg::slcr_pat_t n;
	logic [46:0] step;
	int          ta;
	int          tb;

	// sixteen serial steps per clock, msb first
	function automatic logic [46:0] prbs16(input logic [30:0] s, input int a, input int b);
		logic [30:0] q;
		logic [15:0] o;
		logic        fb;
		q = s;
		o = 16'h0000;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			fb = q[a] ^ q[b];
			o[i] = fb;
			q = {q[29:0], fb};
		end
		return {q, o};
	endfunction

	always_comb begin
		ta = 6;
		tb = 5;
		case (code_in)
			`SLCR_PAT_PRBS9: begin ta = 8; tb = 4; end
			`SLCR_PAT_PRBS15: begin ta = 14; tb = 13; end
			`SLCR_PAT_PRBS23: begin ta = 22; tb = 17; end
			`SLCR_PAT_PRBS31: begin ta = 30; tb = 27; end
			default: begin ta = 6; tb = 5; end
		endcase
		step = prbs16(r.lfsr, ta, tb);
		n = r;
		n.lfsr = step[46:16];
		n.cnt = r.cnt + 16'h0001;
		n.k = 2'b00;
		n.raw = 1'b0;
		case (code_in)
			`SLCR_PAT_PRBS7, `SLCR_PAT_PRBS9, `SLCR_PAT_PRBS15,
			`SLCR_PAT_PRBS23, `SLCR_PAT_PRBS31: n.word = step[15:0];
			`SLCR_PAT_RAMP: n.word = r.cnt;
			`SLCR_PAT_TRANSPORT: n.word = {r.cnt[7:0], ~r.cnt[7:0]};
			`SLCR_PAT_D215: n.word = {2{`SLCR_D21_5}};
			`SLCR_PAT_K285: begin
				n.word = {2{`SLCR_K28_5}};
				n.k = 2'b11;
			end
			`SLCR_PAT_RPAT: n.word = RPAT_TBL[{r.cnt[1:0], 4'h0} +: 16];
			`SLCR_PAT_LOW: begin
				n.word = 16'h0000;
				n.raw = 1'b1;
			end
			`SLCR_PAT_HIGH: begin
				n.word = 16'hffff;
				n.raw = 1'b1;
			end
			`SLCR_PAT_CLOCK: begin
				n.word = `SLCR_CLK_WORD;
				n.raw = 1'b1;
			end
			`SLCR_PAT_K287: begin
				n.word = {2{`SLCR_K28_7}};
				n.k = 2'b11;
			end
			default: n.word = 16'h0000;
		endcase
		if (rst_in) begin
			n = '0;
			n.lfsr = `SLCR_RST_LFSR;
		end
	end

	always_ff @(posedge clk_in) begin
		r <= n;
	end

	assign word_out = r.word;
	assign k_out = r.k;
	assign raw_out = r.raw;
endmodule
`default_nettype wire

// File: slcr_rx_model.sv
// far-end receiver model: holds resync low until it has seen commas
// assumes lane outputs are sampled on the shared reference clock
`timescale 1ns/1ns
`default_nettype none
`include "slcr_defines.svh"
module slcr_rx_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// lane side
	input  wire logic [15:0] data_in,
	input  wire logic [1:0]  k_in,
	input  wire logic [7:0]  lanes_in,
	// request forced by the bench
	input  wire logic        req_in,
	// resync pin, active low
	output logic             resync_n_out
);
	logic [2:0] cnt_r;
	// dead lanes look like loss of signal, so ask again
	always_ff @(posedge clk_in) begin
		if (rst_in || lanes_in == 8'h00 || req_in) begin
			cnt_r        <= 3'h0;
			resync_n_out <= 1'b0;
		end else if (data_in == {2{`SLCR_K28_5}} && k_in == 2'b11 && cnt_r != 3'h4) begin
			cnt_r <= cnt_r + 3'h1;
		end else if (cnt_r == 3'h4) begin
			resync_n_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: slcr_link_regs_tb.sv
// self-checking bench for the link control registers
// assumes the receiver model answers resync; one 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "slcr_defines.svh"
module slcr_link_regs_tb;
	logic        clk, rst, cyc, stb, we, ts_n, req, ack, raw, pd, lrst, cen, mfr, rsn, pin_n;
	logic [11:0] adr, smp;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	logic [15:0] ldat;
	logic [1:0]  lk;
	logic [7:0]  lact, lid;
	logic [31:0] exp_q[$];
	logic [5:0]  md[4] = '{6'h01, 6'h01, 6'h01, 6'h22};
	logic [4:0]  ln[4] = '{5'h00, 5'h02, 5'h03, 5'h02};
	logic        sc[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	logic [4:0]  pc[6] = '{5'h0a, 5'h0b, 5'h0f, 5'h10, 5'h07, 5'h06};
	logic [17:0] pe[6] = '{18'h00000, 18'h0ffff, 18'h000ff, 18'h3fcfc, 18'h3bcbc, 18'h0b5b5};
	// prbs orders rise so a longer register never inherits an all-zero window
	logic [4:0]  pv[8] = '{5'h01, 5'h0d, 5'h02, 5'h03, 5'h0e, 5'h04, 5'h05, 5'h09};
	logic [15:0] e;
	int          error_cnt, tests_run, i;
	slcr_link_regs dut_u (.REF_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .SAMPLE_IN(smp), .SINGLE_ENDED_RESYNC_PIN_N_IN(pin_n),
		.TIMESTAMP_PAIR_INPUT_N_IN(ts_n), .LANE_DATA_OUT(ldat), .LANE_K_OUT(lk),
		.LANE_RAW_OUT(raw), .LANE_ACTIVE_OUT(lact), .RESYNC_REQ_N_OUT(rsn), .SERDES_PD_OUT(pd),
		.LINK_RST_OUT(lrst), .LINK_CLK_EN_OUT(cen), .MF_CNT_RST_OUT(mfr));
	slcr_rx_model rx_u (.clk_in(clk), .rst_in(rst), .data_in(ldat), .k_in(lk),
		.lanes_in(lact), .req_in(req), .resync_n_out(pin_n));
	task automatic stop_test;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		tests_run++;
		if (got !== want) begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	// classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic [9:0] idx, input logic w, input logic [31:0] d);
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {idx, 2'b00};
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] idx, input logic [31:0] x);
		exp_q.push_back(x);
		wb(idx, 1'b0, 32'h0);
	endtask
	task automatic cfg(input logic [9:0] idx, input logic [7:0] v);
		wb(`SLCR_IDX_LINK_EN, 1'b1, 32'h0);
		wb(idx, 1'b1, {24'h0, v});
		wb(`SLCR_IDX_LINK_EN, 1'b1, 32'h1);
	endtask
	task automatic lchk(input logic [17:0] x);
		repeat (4) @(posedge clk);
		chk({14'h0, lk, ldat}, {14'h0, x});
	endtask
	// read data is judged at the ack edge, oldest note first
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			chk(rdat, exp_q.pop_front());
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#(20 * 20000);
		error_cnt++;
		stop_test();
	end
	initial begin
		rst  = 1'b1;
		cyc  = 1'b0;
		stb  = 1'b0;
		we   = 1'b0;
		adr  = 12'h000;
		sel  = 4'hf;
		wdat = 32'h0;
		smp  = 12'h000;
		ts_n = 1'b1;
		req  = 1'b0;
		i    = $urandom(32'haaef);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(`SLCR_IDX_LINK_EN, 32'h1);
		rd(`SLCR_IDX_SYNC, 32'h1);
		rd(`SLCR_IDX_LANE, 32'h3);
		rd(`SLCR_IDX_PAT, 32'h0);
		rd(`SLCR_IDX_LID, 32'h0);
		rd(10'h3ff, 32'h0);
		done("reset");
		wb(`SLCR_IDX_LINK_EN, 1'b1, 32'h0);
		repeat (3) @(posedge clk);
		chk({lact, pd, lrst, cen, mfr}, {8'h00, 4'b1101});
		lid = 8'($urandom);
		wb(`SLCR_IDX_LID, 1'b1, {24'h0, lid});
		sel <= 4'he;
		wb(`SLCR_IDX_LID, 1'b1, 32'h0);
		sel <= 4'hf;
		rd(`SLCR_IDX_LID, {24'h0, lid});
		// every stored bit set, reserved bits kept at zero
		wb(`SLCR_IDX_LANE, 1'b1, 32'h1f);
		rd(`SLCR_IDX_LANE, 32'h1f);
		done("disable and access");
		wb(`SLCR_IDX_LANE, 1'b1, 32'h03);
		wb(`SLCR_IDX_MODE, 1'b1, 32'h01);
		wb(`SLCR_IDX_LINK_EN, 1'b1, 32'h1);
		for (i = 0; i < 400 && !(ldat === 16'h9c00 && lk === 2'b10); i++) @(posedge clk);
		@(posedge clk);
		chk({lk, ldat}, {2'b00, lid, 8'h00});
		chk(lact, 8'h03);
		done("alignment");
		smp <= 12'($urandom);
		for (i = 0; i < 4; i++) begin
			wb(`SLCR_IDX_LINK_EN, 1'b1, 32'h0);
			wb(`SLCR_IDX_MODE, 1'b1, {26'h0, md[i]});
			wb(`SLCR_IDX_LANE, 1'b1, {27'h0, ln[i]});
			wb(`SLCR_IDX_LINK_EN, 1'b1, 32'h1);
			repeat (150) @(posedge clk);
			e = {smp ^ {~ln[i][1], 11'h0}, 4'h0};
			chk({31'h0, ldat !== e}, {31'h0, sc[i]});
		end
		done("format and whitening");
		cfg(`SLCR_IDX_MODE, 8'h01);
		cfg(`SLCR_IDX_LANE, 8'h13);
		repeat (4) @(posedge clk);
		chk(lact, 8'h30);
		done("lane mapping");
		req <= 1'b1;
		repeat (6) @(posedge clk);
		chk(rsn, 1'b0);
		req <= 1'b0;
		cfg(`SLCR_IDX_LANE, 8'h0b);
		req <= 1'b1;
		repeat (6) @(posedge clk);
		chk(rsn, 1'b1);
		wb(`SLCR_IDX_SYNC, 1'b1, 32'h0);
		repeat (3) @(posedge clk);
		chk(rsn, 1'b0);
		wb(`SLCR_IDX_SYNC, 1'b1, 32'h1);
		req <= 1'b0;
		wb(`SLCR_IDX_TSRX, 1'b1, 32'h1);
		cfg(`SLCR_IDX_LANE, 8'h07);
		// pin held low must not count while the pair is the source
		req  <= 1'b1;
		repeat (6) @(posedge clk);
		chk(rsn, 1'b1);
		req  <= 1'b0;
		ts_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk(rsn, 1'b0);
		ts_n <= 1'b1;
		done("resync sources");
		for (i = 0; i < 6; i++) begin
			cfg(`SLCR_IDX_PAT, {3'h0, pc[i]});
			lchk(pe[i]);
			lchk(pe[i]);
		end
		for (i = 0; i < 8; i++) begin
			cfg(`SLCR_IDX_PAT, {3'h0, pv[i]});
			repeat (4) @(posedge clk);
			e = ldat;
			@(posedge clk);
			chk({31'h0, ldat !== e}, 32'h1);
		end
		// repeated alignment: identifier must come round twice
		cfg(`SLCR_IDX_PAT, 8'h08);
		repeat (2) begin
			for (i = 0; i < 200 && !(ldat === 16'h9c00 && lk === 2'b10); i++) @(posedge clk);
			@(posedge clk);
			chk({lk, ldat}, {2'b00, lid, 8'h00});
		end
		cfg(`SLCR_IDX_PAT, 8'h00);
		rd(`SLCR_IDX_PAT, 32'h0);
		done("patterns");
		stop_test();
	end
endmodule
`default_nettype wire
